//--- verilog/phy_mgmt_params.svh
// Constants of the PHY management register bank.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PHY_MGMT_PARAMS_SVH
`define PHY_MGMT_PARAMS_SVH
// Register indices on the management interface.
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_IDHI 5'h02
// Control word bit positions.
`define CTRL_SPEED 13
`define CTRL_AN_EN 12
`define CTRL_RESTART 9
`define CTRL_DUPLEX 8
`define CTRL_COLTEST 7
// Status word fields.
`define STAT_ABILITY 15:9
`define STAT_ABILITY_VAL 7'h3C
`define STAT_RSVD 8:6
`define STAT_AN_DONE 5
`define STAT_RFAULT 4
`define STAT_AN_ABLE 3
`define STAT_LINK 2
`define STAT_JABBER 1
`define STAT_EXT_CAP 0
// Management frame layout.
`define MDIO_PREAMBLE 6'h20
`define MDIO_HEAD_LAST 6'h0B
`define MDIO_DATA_LAST 6'h0F
`define MDIO_DATA_BITS 6'h10
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`endif

//--- verilog/phy_mgmt_pkg.sv
// Types shared by the management frame slave and the register bank.
// Assumes the constants header is available for inclusion.
package phy_mgmt_pkg;
   // Request from the frame slave to the register bank.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] data;
   } mgmt_req_t;
   // Frame slave states.
   typedef enum logic [2:0] {
      SL_IDLE = 3'h0,
      SL_START = 3'h1,
      SL_HEAD = 3'h2,
      SL_TA_RD = 3'h3,
      SL_DATA_RD = 3'h4,
      SL_TA_WR = 3'h5,
      SL_DATA_WR = 3'h6
   } slave_state_t;
   // All state of the frame slave.
   typedef struct packed {
      slave_state_t st;
      logic mdc_q;
      logic [5:0] cnt;
      logic [15:0] sh;
      logic [4:0] addr;
      logic hit;
      logic mdio_o;
      logic mdio_oe_n;
      mgmt_req_t req;
   } slave_q_t;
   // Writable control bits.
   typedef struct packed {
      logic speed;
      logic an_en;
      logic restart;
      logic duplex;
      logic coltest;
   } ctrl_t;
   // All state of the register bank.
   typedef struct packed {
      logic straps_done;
      ctrl_t ctrl;
      logic [15:0] id_high;
      logic an_done;
      logic rf_lat;
      logic link_lat;
      logic jab_lat;
      logic [15:0] rdata;
      logic col_o;
      logic speed_o;
      logic duplex_o;
      logic an_en_o;
      logic restart_o;
   } bank_q_t;
endpackage : phy_mgmt_pkg

//--- verilog/mdio_frame_slave.sv
// Serial management frame slave: decodes read and write frames.
// Assumes MDC is synchronous to clk and at most a quarter of its rate.
`timescale 1ns/1ps
`include "phy_mgmt_params.svh"
module mdio_frame_slave #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mdc_in,
   input wire logic mdio_in,
   input wire logic [15:0] rd_data_in,
   output phy_mgmt_pkg::mgmt_req_t req_out,
   output logic mdio_out,
   output logic mdio_oe_n_out
);
   phy_mgmt_pkg::slave_q_t q;
   phy_mgmt_pkg::slave_q_t n;
   logic [15:0] sh_in;

   // **********************************************************************
   // Frame decoder
   // **********************************************************************
   // Each rising MDC edge advances the frame by one bit.
   always_comb begin
      n = q;
      n.mdc_q = mdc_in;
      n.req.rd = 1'b0;
      n.req.wr = 1'b0;
      sh_in = {q.sh[14:0], mdio_in};
      if (mdc_in && !q.mdc_q) begin
         case (q.st)
            phy_mgmt_pkg::SL_IDLE: begin
               if (mdio_in) begin
                  if (q.cnt != `MDIO_PREAMBLE) begin
                     n.cnt = q.cnt + 6'h01;
                  end
               end else if (q.cnt == `MDIO_PREAMBLE) begin
                  n.st = phy_mgmt_pkg::SL_START;
               end else begin
                  n.cnt = 6'h00;
               end
            end
            phy_mgmt_pkg::SL_START: begin
               n.cnt = 6'h00;
               n.st = mdio_in ? phy_mgmt_pkg::SL_HEAD : phy_mgmt_pkg::SL_IDLE;
            end
            phy_mgmt_pkg::SL_HEAD: begin
               n.sh = sh_in;
               n.cnt = q.cnt + 6'h01;
               if (q.cnt == `MDIO_HEAD_LAST) begin
                  n.cnt = 6'h00;
                  n.addr = sh_in[4:0];
                  n.hit = (sh_in[9:5] == PHY_ADDR);
                  n.st = phy_mgmt_pkg::SL_IDLE;
                  if (sh_in[11:10] == `MDIO_OP_WRITE) begin
                     n.st = phy_mgmt_pkg::SL_TA_WR;
                  end else if (sh_in[11:10] == `MDIO_OP_READ && n.hit) begin
                     n.st = phy_mgmt_pkg::SL_TA_RD;
                     n.req.rd = 1'b1;
                     n.req.addr = sh_in[4:0];
                  end
               end
            end
            phy_mgmt_pkg::SL_TA_RD: begin
               // Second turnaround bit is driven low, data is loaded.
               n.mdio_o = 1'b0;
               n.mdio_oe_n = 1'b0;
               n.sh = rd_data_in;
               n.st = phy_mgmt_pkg::SL_DATA_RD;
            end
            phy_mgmt_pkg::SL_DATA_RD: begin
               n.cnt = q.cnt + 6'h01;
               n.mdio_o = q.sh[15];
               n.sh = {q.sh[14:0], 1'b0};
               if (q.cnt == `MDIO_DATA_BITS) begin
                  n.mdio_oe_n = 1'b1;
                  n.cnt = 6'h00;
                  n.st = phy_mgmt_pkg::SL_IDLE;
               end
            end
            phy_mgmt_pkg::SL_TA_WR: begin
               n.cnt = q.cnt + 6'h01;
               if (q.cnt != 6'h00) begin
                  n.cnt = 6'h00;
                  n.st = phy_mgmt_pkg::SL_DATA_WR;
               end
            end
            phy_mgmt_pkg::SL_DATA_WR: begin
               n.sh = sh_in;
               n.cnt = q.cnt + 6'h01;
               if (q.cnt == `MDIO_DATA_LAST) begin
                  n.cnt = 6'h00;
                  n.req.wr = q.hit;
                  n.req.addr = q.addr;
                  n.req.data = sh_in;
                  n.st = phy_mgmt_pkg::SL_IDLE;
               end
            end
            default: begin
               n.st = phy_mgmt_pkg::SL_IDLE;
            end
         endcase
      end
   end

   // State register; the pin is released after reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.mdio_oe_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign req_out = q.req;
   assign mdio_out = q.mdio_o;
   assign mdio_oe_n_out = q.mdio_oe_n;
endmodule : mdio_frame_slave

//--- verilog/phy_basic_mgmt_registers.sv
// Basic control, status and identifier registers of one 10/100 PHY port.
// Assumes all inputs synchronous to MCLK_IN and straps stable at reset.
// How it works
// (RULE1) Writing restart bit 9 restarts negotiation.
// (RULE2) Bit 8 selects manual half or full duplex.
// (RULE3) Bit 7 forces collision while transmitting.
// (RULE4) Software uses collision test only in loopback.
// (RULE5) Speed default is negotiation strap OR speed strap.
// (RULE6) Negotiation enable default follows negotiation strap.
// (RULE7) Duplex default is NOT negotiation AND duplex.
// (RULE8) Ability bits 14..11 one, 15..9 others zero.
// (RULE9) Status bit 5 shows negotiation complete.
// (RULE10) Status bit 4 latches remote fault high.
// (RULE11) Status bit 3 always reads one.
// (RULE12) Status bit 2 latches link down low.
// (RULE13) Status bit 1 latches jabber high.
// (RULE14) Status bit 0 always reads one.
// (RULE15) Index 2 holds writable identifier high word.
// (RULE16) Status at index 1, reserved 8..6 zero.
// (RULE17) Negotiation enabled overrides speed and duplex.
// (RULE18) Bit 13 selects manual 10 or 100.
// (RULE19) Latched bits hold until status read.
// (RULE20) Restart bit clears itself after starting.
`timescale 1ns/1ps
`include "phy_mgmt_params.svh"
module phy_basic_mgmt_registers #(
   parameter logic [4:0] PHY_ADDR = 5'h01,
   // Identifier high word after reset; value is arbitrary.
   parameter logic [15:0] ID_HIGH_RESET = 16'h1A2B
) (
   input wire logic MCLK_IN,
   input wire logic ARST_N_IN,
   input wire logic AUTONEG_STRAP_IN,
   input wire logic SPEED_STRAP_IN,
   input wire logic DUPLEX_STRAP_IN,
   input wire logic MDC_IN,
   input wire logic MDIO_IN,
   input wire logic AN_DONE_IN,
   input wire logic NEG_SPEED_IN,
   input wire logic NEG_DUPLEX_IN,
   input wire logic LINK_UP_IN,
   input wire logic JABBER_IN,
   input wire logic REMOTE_FAULT_IN,
   input wire logic TX_EN_IN,
   input wire logic COL_IN,
   output logic MDIO_OUT,
   output logic MDIO_OE_N_OUT,
   output logic COL_OUT,
   output logic SPEED_100_OUT,
   output logic FULL_DUPLEX_OUT,
   output logic AN_ENABLE_OUT,
   output logic AN_RESTART_OUT
);
   initial begin
      if (PHY_ADDR > 5'h1F) begin
         $error("PHY_ADDR out of range");
      end
   end

   logic [1:0] rst_sync_r;
   logic rst_n;
   phy_mgmt_pkg::bank_q_t q;
   phy_mgmt_pkg::bank_q_t n;
   phy_mgmt_pkg::mgmt_req_t req;
   logic stat_rd;

   // **********************************************************************
   // Reset release
   // **********************************************************************
   // Reset is applied at once and released through two flip-flops.
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // **********************************************************************
   // Management frame slave
   // **********************************************************************
   mdio_frame_slave #(
      .PHY_ADDR(PHY_ADDR)
   ) u_slave (
      .clk(MCLK_IN),
      .rst_n(rst_n),
      .mdc_in(MDC_IN),
      .mdio_in(MDIO_IN),
      .rd_data_in(q.rdata),
      .req_out(req),
      .mdio_out(MDIO_OUT),
      .mdio_oe_n_out(MDIO_OE_N_OUT)
   );

   // **********************************************************************
   // Read mux
   // **********************************************************************
   // Builds the word returned for a register index; unmapped reads zero.
   function automatic logic [15:0] read_word(input logic [4:0] a,
                                             input phy_mgmt_pkg::bank_q_t s);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         `REG_CTRL: begin
            w[`CTRL_SPEED] = s.ctrl.speed;
            w[`CTRL_AN_EN] = s.ctrl.an_en;
            w[`CTRL_RESTART] = s.ctrl.restart;
            w[`CTRL_DUPLEX] = s.ctrl.duplex;
            w[`CTRL_COLTEST] = s.ctrl.coltest;
         end
         `REG_STAT: begin
            // (RULE8) Fixed ability bits.
            w[`STAT_ABILITY] = `STAT_ABILITY_VAL;
            // (RULE16) Reserved bits zero.
            w[`STAT_RSVD] = 3'h0;
            // (RULE9) Negotiation complete.
            w[`STAT_AN_DONE] = s.an_done;
            // (RULE10) Latched remote fault.
            w[`STAT_RFAULT] = s.rf_lat;
            // (RULE11) Negotiation ability.
            w[`STAT_AN_ABLE] = 1'b1;
            // (RULE12) Latched link state.
            w[`STAT_LINK] = s.link_lat;
            // (RULE13) Latched jabber.
            w[`STAT_JABBER] = s.jab_lat;
            // (RULE14) Extended capability.
            w[`STAT_EXT_CAP] = 1'b1;
         end
         `REG_IDHI: begin
            w = s.id_high;
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction : read_word

   assign stat_rd = req.rd && (req.addr == `REG_STAT);

   // **********************************************************************
   // Register bank next state
   // **********************************************************************
   // Register writes, strap defaults, latching status and pin outputs.
   always_comb begin
      n = q;
      n.restart_o = 1'b0;
      // (RULE1) Restart bit clears itself.
      // (RULE20) One cycle then zero.
      n.ctrl.restart = 1'b0;
      if (!q.straps_done) begin
         // (RULE5) Speed default from straps.
         n.ctrl.speed = AUTONEG_STRAP_IN | SPEED_STRAP_IN;
         // (RULE6) Negotiation enable default.
         n.ctrl.an_en = AUTONEG_STRAP_IN;
         // (RULE7) Duplex default from straps.
         n.ctrl.duplex = !AUTONEG_STRAP_IN & DUPLEX_STRAP_IN;
         n.straps_done = 1'b1;
      end else if (req.wr) begin
         case (req.addr)
            `REG_CTRL: begin
               n.ctrl.speed = req.data[`CTRL_SPEED];
               n.ctrl.an_en = req.data[`CTRL_AN_EN];
               // (RULE1) Writing one starts restart.
               n.ctrl.restart = req.data[`CTRL_RESTART];
               n.restart_o = req.data[`CTRL_RESTART];
               n.ctrl.duplex = req.data[`CTRL_DUPLEX];
               n.ctrl.coltest = req.data[`CTRL_COLTEST];
            end
            `REG_IDHI: begin
               // (RULE15) Identifier high is writable.
               n.id_high = req.data;
            end
            default: begin
               n.id_high = q.id_high;
            end
         endcase
      end
      if (req.rd) begin
         n.rdata = read_word(req.addr, q);
      end
      n.an_done = AN_DONE_IN;
      // (RULE19) Read reloads from live, else hold; event wins.
      n.rf_lat = stat_rd ? REMOTE_FAULT_IN : (q.rf_lat | REMOTE_FAULT_IN);
      n.jab_lat = stat_rd ? JABBER_IN : (q.jab_lat | JABBER_IN);
      n.link_lat = stat_rd ? LINK_UP_IN : (q.link_lat & LINK_UP_IN);
      // (RULE3) Collision test during transmit.
      n.col_o = COL_IN | (q.ctrl.coltest & TX_EN_IN);
      // (RULE17) Negotiated result overrides manual bits.
      // (RULE18) Manual speed when negotiation off.
      n.speed_o = q.ctrl.an_en ? NEG_SPEED_IN : q.ctrl.speed;
      // (RULE2) Manual duplex when negotiation off.
      n.duplex_o = q.ctrl.an_en ? NEG_DUPLEX_IN : q.ctrl.duplex;
      n.an_en_o = q.ctrl.an_en;
   end

   // State register of the bank.
   always_ff @(posedge MCLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.id_high <= ID_HIGH_RESET;
      end else begin
         q <= n;
      end
   end

   assign COL_OUT = q.col_o;
   assign SPEED_100_OUT = q.speed_o;
   assign FULL_DUPLEX_OUT = q.duplex_o;
   assign AN_ENABLE_OUT = q.an_en_o;
   assign AN_RESTART_OUT = q.restart_o;

   // **********************************************************************
   // Checks
   // **********************************************************************
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!rst_n);

   sequence s_ctrl_wr;
      q.straps_done && req.wr && req.addr == `REG_CTRL;
   endsequence
   sequence s_restart_pulse;
      AN_RESTART_OUT && q.ctrl.restart ##1 !AN_RESTART_OUT && !q.ctrl.restart;
   endsequence
   sequence s_stat_rd;
      req.rd && req.addr == `REG_STAT;
   endsequence

   // A written one gives one pulse, then reads zero.
   chk_restart_selfclear: assert property ( // RULE1
      s_ctrl_wr ##0 req.data[`CTRL_RESTART] |=> s_restart_pulse)
      else $error("restart bit did not pulse and clear");

   // A written zero gives no pulse.
   chk_restart_zero: assert property ( // RULE20
      s_ctrl_wr ##0 !req.data[`CTRL_RESTART] |=> !AN_RESTART_OUT)
      else $error("restart fired on zero write");

   // Control writes land one edge after the request.
   chk_ctrl_write: assert property ( // RULE2
      s_ctrl_wr |=> q.ctrl.duplex == $past(req.data[`CTRL_DUPLEX])
         && q.ctrl.speed == $past(req.data[`CTRL_SPEED])
         && q.ctrl.coltest == $past(req.data[`CTRL_COLTEST]))
      else $error("control write lost");

   // Manual duplex while negotiation is off.
   chk_duplex_manual: assert property ( // RULE2
      !q.ctrl.an_en |=> FULL_DUPLEX_OUT == $past(q.ctrl.duplex))
      else $error("manual duplex not applied");

   // Manual speed while negotiation is off.
   chk_speed_manual: assert property ( // RULE18
      !q.ctrl.an_en |=> SPEED_100_OUT == $past(q.ctrl.speed))
      else $error("manual speed not applied");

   // Negotiated result drives both pins.
   chk_an_override: assert property ( // RULE17
      q.ctrl.an_en |=> SPEED_100_OUT == $past(NEG_SPEED_IN)
         && FULL_DUPLEX_OUT == $past(NEG_DUPLEX_IN))
      else $error("negotiated result not applied");

   // The enable pin mirrors the stored bit.
   chk_an_enable_pin: assert property ( // RULE6
      q.straps_done |=> AN_ENABLE_OUT == $past(q.ctrl.an_en))
      else $error("negotiation enable pin wrong");

   // Test mode raises collision while transmitting.
   chk_collision_test: assert property ( // RULE3
      q.ctrl.coltest && TX_EN_IN |=> COL_OUT)
      else $error("collision test inactive during transmit");

   // A real collision always passes through.
   chk_collision_pass: assert property ( // RULE3
      COL_IN |=> COL_OUT)
      else $error("real collision not passed through");

   // No transmit and no collision keeps it low.
   chk_collision_idle: assert property ( // RULE3
      !COL_IN && !TX_EN_IN |=> !COL_OUT)
      else $error("collision without cause");

   // Strap defaults are taken once after reset.
   chk_strap_speed: assert property ( // RULE5
      $rose(q.straps_done) |-> q.ctrl.speed
         == ($past(AUTONEG_STRAP_IN) | $past(SPEED_STRAP_IN)))
      else $error("speed default wrong");

   chk_strap_an: assert property ( // RULE6
      $rose(q.straps_done) |-> q.ctrl.an_en == $past(AUTONEG_STRAP_IN))
      else $error("negotiation default wrong");

   chk_strap_duplex: assert property ( // RULE7
      $rose(q.straps_done) |-> q.ctrl.duplex
         == (!$past(AUTONEG_STRAP_IN) & $past(DUPLEX_STRAP_IN)))
      else $error("duplex default wrong");

   // Ability and reserved bits are fixed.
   chk_status_fixed: assert property ( // RULE8
      s_stat_rd |=> q.rdata[15:6] == {`STAT_ABILITY_VAL, 3'h0})
      else $error("status ability or reserved bits wrong");

   // The two constant ones of the status word.
   chk_status_able: assert property ( // RULE11
      s_stat_rd |=> q.rdata[`STAT_AN_ABLE] && q.rdata[`STAT_EXT_CAP])
      else $error("status constant ones wrong");

   // Completion follows the registered input.
   chk_an_complete: assert property ( // RULE9
      s_stat_rd |=> q.rdata[`STAT_AN_DONE] == $past(q.an_done))
      else $error("negotiation complete bit wrong");

   // Unmapped indices read as zero.
   chk_unmapped_read: assert property ( // RULE16
      req.rd && req.addr > `REG_IDHI |=> q.rdata == 16'h0000)
      else $error("unmapped index not read as zero");

   // Jabber stays latched high until read.
   chk_jabber_latch: assert property ( // RULE13
      JABBER_IN ##1 !stat_rd [*2] |-> q.jab_lat)
      else $error("jabber not latched");

   // Remote fault stays latched high until read.
   chk_fault_latch: assert property ( // RULE10
      REMOTE_FAULT_IN ##1 !stat_rd |-> q.rf_lat)
      else $error("remote fault not latched");

   // A link drop stays latched low until read.
   chk_link_latch: assert property ( // RULE12
      !LINK_UP_IN ##1 !stat_rd [*3] |-> !q.link_lat)
      else $error("link drop not latched");

   // A status read reloads every latch from live.
   chk_latch_reload: assert property ( // RULE19
      stat_rd |=> q.jab_lat == $past(JABBER_IN) && q.link_lat == $past(LINK_UP_IN)
         && q.rf_lat == $past(REMOTE_FAULT_IN))
      else $error("latched bits not reloaded on read");

   // A written identifier word is kept.
   chk_id_write: assert property ( // RULE15
      q.straps_done && req.wr && req.addr == `REG_IDHI |=> q.id_high == $past(req.data))
      else $error("identifier write lost");

   // Without a write the identifier holds.
   chk_id_hold: assert property ( // RULE15
      !(req.wr && req.addr == `REG_IDHI) |=> $stable(q.id_high))
      else $error("identifier changed without write");
endmodule : phy_basic_mgmt_registers

//--- verif/mdio_host_model.sv
// Management host model that clocks serial frames into the PHY register bank.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module mdio_host_model (
   input wire logic clk_in,
   input wire logic mdio_in,
   output logic mdc_out,
   output logic mdio_out,
   output logic mdio_drive_out,
   output logic rd_strobe_out,
   output logic [15:0] rd_word_out
);
   // ****************
   // Frame engine
   // ****************
   // The management clock stands low and the line is released between frames.
   initial begin
      mdc_out = 1'b0;
      mdio_out = 1'b1;
      mdio_drive_out = 1'b0;
      rd_strobe_out = 1'b0;
      rd_word_out = 16'h0000;
   end
   // One bit period of three cycles low and three high; returns the level before the rise.
   task automatic tick(input logic b, input logic drv, output logic seen);
      @(negedge clk_in);
      mdc_out = 1'b0;
      mdio_out = b;
      mdio_drive_out = drv;
      repeat (3) @(negedge clk_in);
      seen = mdio_in;
      mdc_out = 1'b1;
      repeat (2) @(negedge clk_in);
   endtask : tick
   // A whole frame with its own preamble; a read ends with a one-cycle strobe.
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd);
      logic [13:0] head;
      logic [15:0] got;
      logic s;
      head = {2'h1, op, pa, ra};
      got = 16'h0000;
      repeat (32) tick(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) tick(head[i], 1'b1, s);
      if (op == 2'h2) begin
         // First turnaround bit released, second driven low by the device, then data.
         repeat (2) tick(1'b1, 1'b0, s);
         for (int i = 15; i >= 0; i--) begin
            tick(1'b1, 1'b0, s);
            got[i] = s;
         end
      end else begin
         tick(1'b1, 1'b1, s);
         tick(1'b0, 1'b1, s);
         for (int i = 15; i >= 0; i--) tick(wd[i], 1'b1, s);
      end
      @(negedge clk_in);
      mdc_out = 1'b0;
      mdio_drive_out = 1'b0;
      if (op == 2'h2) begin
         rd_word_out = got;
         rd_strobe_out = 1'b1;
         @(negedge clk_in);
         rd_strobe_out = 1'b0;
      end
   endtask : frame
endmodule : mdio_host_model

//--- verif/phy_basic_mgmt_registers_test.sv
// Self-checking bench for the PHY basic control, status and identifier registers.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module phy_basic_mgmt_registers_test;
   // ****************
   // Signals and instances
   // ****************
   logic MCLK_IN = 1'b0, ARST_N_IN = 1'b0, A_S = 1'b0, S_S = 1'b0, D_S = 1'b0;
   logic AN_DONE_IN = 1'b0, NEG_SPEED_IN = 1'b0, NEG_DUPLEX_IN = 1'b0, LINK_UP_IN = 1'b0;
   logic JABBER_IN = 1'b0, REMOTE_FAULT_IN = 1'b0, TX_EN_IN = 1'b0, COL_IN = 1'b0;
   logic MDIO_OUT, MDIO_OE_N_OUT, COL_OUT, SPEED_100_OUT, FULL_DUPLEX_OUT;
   logic AN_ENABLE_OUT, AN_RESTART_OUT, mdc, host_d, host_drv, rd_strobe, mdio_wire;
   logic [15:0] rd_word, e, w;
   logic [15:0] expq[$];
   int num_errors = 0, checked = 0, restart_pulses = 0, seed = 69544, r, p0;
   // Identifier reset word; value is arbitrary.
   localparam logic [15:0] ID_RST = 16'h5C3D;
   // Shared data line: the device when enabled, else the host, else the pull-up.
   assign mdio_wire = (MDIO_OE_N_OUT === 1'b0) ? MDIO_OUT : (host_drv ? host_d : 1'b1);
   always #12.5 MCLK_IN = ~MCLK_IN;
   phy_basic_mgmt_registers #(.PHY_ADDR(5'h01), .ID_HIGH_RESET(ID_RST)) dut (
      .MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .AUTONEG_STRAP_IN(A_S),
      .SPEED_STRAP_IN(S_S), .DUPLEX_STRAP_IN(D_S), .MDC_IN(mdc), .MDIO_IN(mdio_wire),
      .AN_DONE_IN(AN_DONE_IN), .NEG_SPEED_IN(NEG_SPEED_IN), .NEG_DUPLEX_IN(NEG_DUPLEX_IN),
      .LINK_UP_IN(LINK_UP_IN), .JABBER_IN(JABBER_IN), .REMOTE_FAULT_IN(REMOTE_FAULT_IN),
      .TX_EN_IN(TX_EN_IN), .COL_IN(COL_IN), .MDIO_OUT(MDIO_OUT),
      .MDIO_OE_N_OUT(MDIO_OE_N_OUT), .COL_OUT(COL_OUT), .SPEED_100_OUT(SPEED_100_OUT),
      .FULL_DUPLEX_OUT(FULL_DUPLEX_OUT), .AN_ENABLE_OUT(AN_ENABLE_OUT),
      .AN_RESTART_OUT(AN_RESTART_OUT));
   mdio_host_model host (.clk_in(MCLK_IN), .mdio_in(mdio_wire), .mdc_out(mdc),
      .mdio_out(host_d), .mdio_drive_out(host_drv), .rd_strobe_out(rd_strobe),
      .rd_word_out(rd_word));
   // ****************
   // Tasks and watchers
   // ****************
   task automatic results();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // Notes the expected word, then runs the read frame.
   task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] x);
      expq.push_back(x);
      host.frame(2'h2, pa, ra, 16'h0000);
   endtask : rd
   task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
      host.frame(2'h1, pa, ra, d);
      repeat (4) @(negedge MCLK_IN);
   endtask : wr
   task automatic do_reset(input logic [2:0] k);
      @(negedge MCLK_IN);
      ARST_N_IN = 1'b0;
      {A_S, S_S, D_S} = k;
      repeat (8) @(negedge MCLK_IN);
      ARST_N_IN = 1'b1;
      repeat (6) @(negedge MCLK_IN);
   endtask : do_reset
   function automatic logic [15:0] st(logic rf, logic lk, logic jb);
      return {7'h3C, 3'h0, AN_DONE_IN, rf, 1'b1, lk, jb, 1'b1};
   endfunction : st
   // Each read result is compared against the oldest note.
   always @(posedge MCLK_IN) begin
      if (rd_strobe === 1'b1) begin
         e = (expq.size() > 0) ? expq.pop_front() : 16'hXXXX;
         `CHK("read_data", e, rd_word)
      end
   end
   // Pulses are counted away from the edge that launches them.
   always @(negedge MCLK_IN) if (AN_RESTART_OUT === 1'b1) restart_pulses++;
   initial begin
      repeat (40000) @(posedge MCLK_IN);
      num_errors++;
      $display("unexpected timeout expected %h seen %h", 1'b0, 1'b1);
      results();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         {NEG_SPEED_IN, NEG_DUPLEX_IN, AN_DONE_IN} = r[2:0];
         do_reset(i[2:0]);
         `CHK("an_enable", A_S, AN_ENABLE_OUT)
         `CHK("speed", A_S ? NEG_SPEED_IN : S_S, SPEED_100_OUT)
         `CHK("duplex", A_S ? NEG_DUPLEX_IN : D_S, FULL_DUPLEX_OUT)
         rd(5'h01, 5'h00, {2'h0, A_S | S_S, A_S, 3'h0, ~A_S & D_S, 8'h00});
      end
      LINK_UP_IN = 1'b1;
      rd(5'h01, 5'h01, st(1'b0, 1'b0, 1'b0));
      rd(5'h01, 5'h01, st(1'b0, 1'b1, 1'b0));
      {JABBER_IN, REMOTE_FAULT_IN, LINK_UP_IN} = 3'b110;
      repeat (3) @(negedge MCLK_IN);
      {JABBER_IN, REMOTE_FAULT_IN, LINK_UP_IN} = 3'b001;
      rd(5'h01, 5'h01, st(1'b1, 1'b0, 1'b1));
      wr(5'h01, 5'h01, 16'h0000);
      rd(5'h01, 5'h01, st(1'b0, 1'b1, 1'b0));
      rd(5'h01, 5'h05, 16'h0000);
      wr(5'h01, 5'h00, 16'h2180);
      `CHK("speed", 1'b1, SPEED_100_OUT)
      `CHK("duplex", 1'b1, FULL_DUPLEX_OUT)
      rd(5'h01, 5'h00, 16'h2180);
      TX_EN_IN = 1'b1;
      repeat (2) @(negedge MCLK_IN);
      `CHK("collision", 1'b1, COL_OUT)
      TX_EN_IN = 1'b0;
      repeat (2) @(negedge MCLK_IN);
      `CHK("collision", 1'b0, COL_OUT)
      wr(5'h01, 5'h00, 16'h0000);
      TX_EN_IN = 1'b1;
      repeat (2) @(negedge MCLK_IN);
      `CHK("collision", 1'b0, COL_OUT)
      `CHK("speed", 1'b0, SPEED_100_OUT)
      `CHK("duplex", 1'b0, FULL_DUPLEX_OUT)
      COL_IN = 1'b1;
      repeat (2) @(negedge MCLK_IN);
      `CHK("collision", 1'b1, COL_OUT)
      {TX_EN_IN, COL_IN} = 2'b00;
      p0 = restart_pulses;
      wr(5'h01, 5'h00, 16'h0200);
      `CHK("restart", p0 + 1, restart_pulses)
      rd(5'h01, 5'h00, 16'h0000);
      wr(5'h01, 5'h00, 16'h0000);
      `CHK("restart", p0 + 1, restart_pulses)
      wr(5'h01, 5'h00, 16'h1000);
      {NEG_SPEED_IN, NEG_DUPLEX_IN} = 2'b10;
      repeat (3) @(negedge MCLK_IN);
      `CHK("speed", 1'b1, SPEED_100_OUT)
      `CHK("duplex", 1'b0, FULL_DUPLEX_OUT)
      rd(5'h01, 5'h02, ID_RST);
      r = $random(seed);
      w = r[15:0];
      wr(5'h01, 5'h02, w);
      wr(5'h07, 5'h02, ~w);
      rd(5'h01, 5'h02, w);
      rd(5'h07, 5'h02, 16'hFFFF);
      repeat (20) @(negedge MCLK_IN);
      `CHK("pending_reads", 0, expq.size())
      results();
   end
endmodule : phy_basic_mgmt_registers_test
